/* File: src/isq_top.sv */
// instruction sequencer: phases, prefetch pipeline, program counter and return stack
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps

module isq_top
(
  input wire logic REF_CLK,
  input wire logic RST,
  // program memory
  output logic [isq_pkg::PC_W-1:0] PM_ADDR,
  input wire logic [isq_pkg::WORD_W-1:0] PM_DATA,
  // executor side
  output isq_pkg::isq_instr_s INSTR,
  output isq_pkg::isq_phase_e PHASE,
  input wire isq_pkg::isq_exec_s EXEC,
  // interrupt request logic
  input wire logic IRQ_REQ,
  input wire logic [isq_pkg::PC_W-1:0] IRQ_VECTOR,
  output logic IRQ_ACK,
  output logic STACK_FULL,
  // apb slave
  input wire logic [isq_pkg::APB_AW-1:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [isq_pkg::APB_DW-1:0] PWDATA,
  output logic [isq_pkg::APB_DW-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);

  // ==========================================================
  // timing overview
  // four clocks make one instruction cycle, T1 to T4
  // the T1 edge fetches the word at the program counter and steps the counter
  // the T4 edge applies the flow of the executing instruction and moves the fetched word into the execute slot
  // a flow change leaves a dummy slot, so a branch costs a second instruction cycle
  // the executor must present its flow report during T4, it is ignored otherwise

  // ==========================================================
  // state
  isq_pkg::isq_phase_e phase_reg;
  isq_pkg::isq_phase_e phase_next;
  logic [isq_pkg::PC_W-1:0] pc_reg;
  logic [isq_pkg::PC_W-1:0] pc_next;
  logic [isq_pkg::PC_W-1:0] fetch_addr_reg;
  logic [isq_pkg::WORD_W-1:0] fetch_word_reg;
  isq_pkg::isq_instr_s ir_reg;
  logic [isq_pkg::PC_W-1:0] stk_reg [isq_pkg::STK_DEPTH];
  logic [isq_pkg::LVL_W-1:0] lvl_reg;
  logic ack_reg;
  logic [isq_pkg::APB_DW-1:0] prdata_reg;

  // ==========================================================
  // decode of the current cycle
  logic cycle_end;
  logic fetch_edge;
  logic stk_full;
  logic hit;
  logic pcl_wr;
  logic slot_end;
  logic do_push;
  logic do_pop;
  logic irq_take;
  logic flush;
  isq_pkg::isq_flow_e flow;
  logic [isq_pkg::PC_W-1:0] push_val;

  // low byte jump keeps the page of the instruction doing the write
  function automatic logic [isq_pkg::PC_W-1:0] page_jump
  (
    input logic [isq_pkg::PC_W-1:0] base,
    input logic [isq_pkg::PCL_W-1:0] low
  );
    page_jump = {base[isq_pkg::PC_W-1:isq_pkg::PCL_W], low};
  endfunction

  // low byte as a bus word, upper bits read back as zero
  function automatic logic [isq_pkg::APB_DW-1:0] low_byte_word
  (
    input logic [isq_pkg::PC_W-1:0] addr
  );
    low_byte_word = {{(isq_pkg::APB_DW - isq_pkg::PCL_W){1'b0}}, addr[isq_pkg::PCL_W-1:0]};
  endfunction

  // next phase in the gray sequence
  always_comb
  begin
    unique case (phase_reg)
      isq_pkg::PH_T1: phase_next = isq_pkg::PH_T2;
      isq_pkg::PH_T2: phase_next = isq_pkg::PH_T3;
      isq_pkg::PH_T3: phase_next = isq_pkg::PH_T4;
      isq_pkg::PH_T4: phase_next = isq_pkg::PH_T1;
    endcase
  end

  // phase counter runs free from reset
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      phase_reg <= isq_pkg::PH_T1;
    else
      phase_reg <= phase_next;
  end

  // phase strobes, stack level and register decode
  assign fetch_edge = (phase_reg == isq_pkg::PH_T1);
  assign cycle_end = (phase_reg == isq_pkg::PH_T4);
  assign stk_full = (lvl_reg == isq_pkg::LVL_FULL);
  assign hit = (PADDR == isq_pkg::PCL_OFFSET);
  // a software write lands only on the last phase, so the pipeline sees it once
  assign pcl_wr = PSEL && PENABLE && PWRITE && hit && cycle_end;

  // last phase of a cycle that no software write has claimed
  assign slot_end = cycle_end && !pcl_wr;

  // flow of the executing instruction; a dummy slot never changes flow
  assign flow = ir_reg.valid ? EXEC.flow : isq_pkg::FLOW_SEQ;

  // interrupts wait while the stack is full, the request stays with its source
  // a dummy slot counts as sequential, so a return that frees a level lets it in
  assign irq_take = IRQ_REQ && !stk_full && slot_end
    && (flow == isq_pkg::FLOW_SEQ);

  // calls push even on a full stack
  assign do_push = slot_end
    && ((flow == isq_pkg::FLOW_CALL) || irq_take);
  assign do_pop = slot_end
    && ((flow == isq_pkg::FLOW_RET) || (flow == isq_pkg::FLOW_INTERRUPT_EXIT_INSTR));

  // return address is the prefetched one, which the flush then discards
  assign push_val = fetch_addr_reg;

  // any flow change drops the prefetched word and leaves a dummy slot
  assign flush = cycle_end && (pcl_wr || irq_take
    || (flow != isq_pkg::FLOW_SEQ));

  // program counter next value
  // fetch step first, then software write, interrupt and executor flow
  always_comb
  begin
    pc_next = pc_reg;
    if (fetch_edge)
      pc_next = pc_reg + isq_pkg::PC_ONE;
    else if (cycle_end)
    begin
      if (pcl_wr)
        pc_next = page_jump(ir_reg.addr, PWDATA[isq_pkg::PCL_W-1:0]);
      else if (irq_take)
        pc_next = IRQ_VECTOR;
      else
      begin
        unique case (flow)
          isq_pkg::FLOW_JUMP: pc_next = EXEC.target;
          isq_pkg::FLOW_CALL: pc_next = EXEC.target;
          isq_pkg::FLOW_RET: pc_next = stk_reg[0];
          isq_pkg::FLOW_INTERRUPT_EXIT_INSTR: pc_next = stk_reg[0];
          isq_pkg::FLOW_SKIP: pc_next = pc_reg;
          isq_pkg::FLOW_SEQ: pc_next = pc_reg;
          default: pc_next = pc_reg;
        endcase
      end
    end
  end

  // program counter, loaded from the reset vector
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      pc_reg <= isq_pkg::RESET_VECTOR;
    else
      pc_reg <= pc_next;
  end

  // fetch stage: the next word is read while the current one executes
  // the memory is read combinationally, its word must settle within T1
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      fetch_addr_reg <= isq_pkg::RESET_VECTOR;
      fetch_word_reg <= isq_pkg::WORD_ZERO;
    end
    else if (fetch_edge)
    begin
      fetch_addr_reg <= pc_reg;
      fetch_word_reg <= PM_DATA;
    end
  end

  // execute stage: fetched word moves in at the cycle boundary
  // a flushed slot keeps its address, so a low byte read still names it
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      ir_reg.addr <= isq_pkg::RESET_VECTOR;
      ir_reg.word <= isq_pkg::WORD_ZERO;
      ir_reg.valid <= 1'b0;
    end
    else if (cycle_end)
    begin
      ir_reg.addr <= fetch_addr_reg;
      ir_reg.word <= fetch_word_reg;
      ir_reg.valid <= !flush;
    end
  end

  // ==========================================================
  // return stack
  // entry 0 is the top; a push shifts down so the oldest falls off when full
  // there is no overflow flag, software must keep calls within two levels
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      stk_reg[0] <= isq_pkg::RESET_VECTOR;
      stk_reg[1] <= isq_pkg::RESET_VECTOR;
    end
    else if (do_push)
    begin
      stk_reg[0] <= push_val;
      stk_reg[1] <= stk_reg[0];
    end
    else if (do_pop)
    begin
      stk_reg[0] <= stk_reg[1];
      stk_reg[1] <= stk_reg[1];
    end
  end

  // level pointer; no bus path reaches it or the entries
  // a pop on an empty stack leaves the level at empty
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      lvl_reg <= isq_pkg::LVL_EMPTY;
    else if (do_push && !stk_full)
      lvl_reg <= lvl_reg + isq_pkg::LVL_ONE;
    else if (do_push)
      lvl_reg <= isq_pkg::LVL_FULL;
    else if (do_pop && (lvl_reg != isq_pkg::LVL_EMPTY))
      lvl_reg <= lvl_reg - isq_pkg::LVL_ONE;
  end

  // acknowledge pulse toward the request logic
  // one clock wide; the requester clears its flag on seeing it
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      ack_reg <= 1'b0;
    else
      ack_reg <= irq_take;
  end

  // ==========================================================
  // apb slave
  // read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      prdata_reg <= isq_pkg::RDATA_ZERO;
    else if (PSEL && !PENABLE)
    begin
      if (hit)
        prdata_reg <= low_byte_word(ir_reg.addr);
      else
        prdata_reg <= isq_pkg::RDATA_ZERO;
    end
  end

  // writes wait for the last phase; reads and errors answer at once
  assign PREADY = !(PSEL && PENABLE && PWRITE && hit) || cycle_end;

  // only the low byte is mapped, any other offset answers with an error
  assign PSLVERR = PSEL && PENABLE && !hit;

  // read data straight from its flop, held until the next setup cycle
  assign PRDATA = prdata_reg;

  // ==========================================================
  // outputs
  // all of them come straight from registers or one level of decode
  assign PM_ADDR = pc_reg;
  assign INSTR = ir_reg;
  assign PHASE = phase_reg;
  assign IRQ_ACK = ack_reg;
  assign STACK_FULL = stk_full;

endmodule

/* File: src/isq_pkg.sv */
// shared constants and types of the instruction sequencer
package isq_pkg;

  // ==========================================================
  // widths
  localparam int PC_W = 10;
  localparam int PCL_W = 8;
  localparam int PAGE_W = 2;
  localparam int WORD_W = 14;
  localparam int STK_DEPTH = 2;
  localparam int LVL_W = 2;
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;

  // ==========================================================
  // reset values and vectors
  localparam logic [PC_W-1:0] RESET_VECTOR = 10'h000;
  localparam logic [PC_W-1:0] PC_ONE = 10'h001;
  localparam logic [LVL_W-1:0] LVL_EMPTY = 2'h0;
  localparam logic [LVL_W-1:0] LVL_ONE = 2'h1;
  localparam logic [LVL_W-1:0] LVL_FULL = 2'h2;
  localparam logic [WORD_W-1:0] WORD_ZERO = 14'h0000;

  // ==========================================================
  // register map
  localparam logic [APB_AW-1:0] PCL_OFFSET = 12'h000;
  localparam logic [APB_DW-1:0] RDATA_ZERO = 32'h00000000;

  // ==========================================================
  // types
  // instruction phases, gray coded along the cycle
  typedef enum logic [1:0] {
    PH_T1 = 2'h0,
    PH_T2 = 2'h1,
    PH_T3 = 2'h3,
    PH_T4 = 2'h2
  } isq_phase_e;

  // flow effect reported by the executor for the current instruction
  typedef enum logic [2:0] {
    FLOW_SEQ = 3'h0,
    FLOW_JUMP = 3'h1,
    FLOW_CALL = 3'h2,
    FLOW_RET = 3'h3,
    FLOW_INTERRUPT_EXIT_INSTR = 3'h4,
    FLOW_SKIP = 3'h5
  } isq_flow_e;

  typedef struct packed {
    isq_flow_e flow;
    logic [PC_W-1:0] target;
  } isq_exec_s;

  typedef struct packed {
    logic [PC_W-1:0] addr;
    logic [WORD_W-1:0] word;
    logic valid;
  } isq_instr_s;

endpackage

/* File: sim/isq_asserts.sv */
// port checks of the instruction sequencer
`timescale 1ns/1ps
// ====
// checker
module isq_asserts
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [9:0] PM_ADDR,
  input wire isq_pkg::isq_instr_s INSTR,
  input wire isq_pkg::isq_phase_e PHASE,
  input wire isq_pkg::isq_exec_s EXEC,
  input wire logic [9:0] IRQ_VECTOR,
  input wire logic IRQ_ACK,
  input wire logic STACK_FULL,
  input wire logic [11:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // executed instruction at T4, split by flow kind
  wire t4 = PHASE == isq_pkg::PH_T4 && INSTR.valid;
  // a low byte write in the same phase overrides the branch target
  wire br = t4 && EXEC.flow inside {isq_pkg::FLOW_JUMP, isq_pkg::FLOW_CALL}
    && !(PSEL && PENABLE && PADDR == 12'h000);
  chk_phase_t1: assert property (
    PHASE == isq_pkg::PH_T1 |=> PHASE == isq_pkg::PH_T2) else $error("phase after T1");
  chk_phase_wrap: assert property (
    PHASE == isq_pkg::PH_T4 |=> PHASE == isq_pkg::PH_T1) else $error("phase after T4");
  chk_pc_step: assert property (
    PHASE == isq_pkg::PH_T1 |=> PM_ADDR == $past(PM_ADDR) + 10'h001) else $error("pc step");
  chk_instr_t4: assert property (
    $changed(INSTR) && !$past(RST) |-> $past(PHASE) == isq_pkg::PH_T4) else $error("instr moved");
  // target only after one dummy instruction cycle
  chk_branch_dummy: assert property (
    br |=> !INSTR.valid ##4 (INSTR.valid || IRQ_ACK) && INSTR.addr == $past(EXEC.target, 5))
    else $error("branch timing");
  chk_skip_dummy: assert property (
    t4 && EXEC.flow == isq_pkg::FLOW_SKIP |=> !INSTR.valid[*4]) else $error("skip slot");
  chk_ack_room: assert property (
    IRQ_ACK |-> !$past(STACK_FULL)) else $error("ack on full stack");
  chk_ack_vector: assert property (
    IRQ_ACK |-> PM_ADDR == $past(IRQ_VECTOR) && PHASE == isq_pkg::PH_T1) else $error("vector");
  chk_apb_unmapped: assert property (
    PSEL && PENABLE && PADDR != 12'h000 |-> PREADY && PSLVERR) else $error("unmapped");
  cover property (IRQ_ACK);
  cover property (br && STACK_FULL);
  cover property (PSLVERR);
endmodule

bind isq_top isq_asserts i_chk (.REF_CLK(REF_CLK), .RST(RST), .PM_ADDR(PM_ADDR),
  .INSTR(INSTR), .PHASE(PHASE), .EXEC(EXEC), .IRQ_VECTOR(IRQ_VECTOR), .IRQ_ACK(IRQ_ACK),
  .STACK_FULL(STACK_FULL), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE),
  .PREADY(PREADY), .PSLVERR(PSLVERR));

/* File: sim/isq_pm_model.sv */
// program memory and interrupt requester beside the sequencer
`timescale 1ns/1ps
// ====
// model
module isq_pm_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [9:0] addr,
  output logic [13:0] data,
  input wire logic irq_go,
  input wire logic ack,
  output logic req,
  output logic [9:0] vector,
  output int n_ack
);
  // rom word carries its own address, so a wrong fetch shows
  assign data = {4'ha, addr};
  assign vector = 10'h3f0;
  // request stays pending while acks are withheld
  always_ff @(posedge clk)
  begin
    if (rst || ack)
      req <= 1'b0;
    else if (irq_go)
      req <= 1'b1;
  end
  // ack counter
  always_ff @(posedge clk)
  begin
    if (rst)
      n_ack <= 0;
    else if (ack)
      n_ack <= n_ack + 1;
  end
endmodule

/* File: sim/isq_tb_top.sv */
// directed bench of the instruction sequencer
`timescale 1ns/1ps
// ====
// bench
module isq_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] pm_addr, irq_vec;
  logic [13:0] pm_data;
  isq_pkg::isq_instr_s instr;
  isq_pkg::isq_phase_e phase;
  isq_pkg::isq_exec_s ex = '0;
  logic irq_req, irq_ack, full, pready, err;
  logic irq_go = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int n_fail = 0, num_checks = 0, n_ack;
  always #2.5 ref_clk = ~ref_clk;
  isq_top i_dut (.REF_CLK(ref_clk), .RST(rst), .PM_ADDR(pm_addr), .PM_DATA(pm_data),
    .INSTR(instr), .PHASE(phase), .EXEC(ex), .IRQ_REQ(irq_req), .IRQ_VECTOR(irq_vec),
    .IRQ_ACK(irq_ack), .STACK_FULL(full), .PADDR(paddr), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(err));
  isq_pm_model i_pm (.clk(ref_clk), .rst(rst), .addr(pm_addr), .data(pm_data),
    .irq_go(irq_go), .ack(irq_ack), .req(irq_req), .vector(irq_vec), .n_ack(n_ack));
  // ====
  // tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // wait for a phase of a real, non-dummy instruction
  task automatic wait_ph(input isq_pkg::isq_phase_e p);
    do @(posedge ref_clk); while (!(phase === p && instr.valid === 1'b1));
  endtask
  // flow is offered for one T4 edge only, then the next instruction is checked
  task automatic run(input isq_pkg::isq_flow_e f, input logic [9:0] t, input logic [9:0] e);
    wait_ph(isq_pkg::PH_T3);
    ex <= '{f, t};
    @(posedge ref_clk);
    ex <= '0;
    wait_ph(isq_pkg::PH_T1);
    check("instr addr", instr.addr, e);
  endtask
  // apb transfer; a write may stall until its T4 edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    pen <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // ====
  // sequence
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    check("stack empty", full, 0);
    wait_ph(isq_pkg::PH_T1);
    check("reset addr", instr.addr, 0);
    run(isq_pkg::FLOW_SEQ, 0, 10'h001);
    check("word", instr.word, 14'h2801);
    run(isq_pkg::FLOW_JUMP, 10'h155, 10'h155);
    run(isq_pkg::FLOW_SKIP, 0, 10'h157);
    run(isq_pkg::FLOW_SEQ, 0, 10'h158);
    apb(1'b1, 12'h000, 32'hffffff40);
    wait_ph(isq_pkg::PH_T1);
    check("page jump", instr.addr, 10'h140);
    apb(1'b0, 12'h000, 0);
    check("low byte", rd, 32'h40);
    apb(1'b0, 12'h004, 0);
    check("unmapped", {rd[30:0], err}, 1);
    run(isq_pkg::FLOW_CALL, 10'h200, 10'h200);
    run(isq_pkg::FLOW_CALL, 10'h300, 10'h300);
    check("full", full, 1);
    irq_go <= 1'b1;
    @(posedge ref_clk);
    irq_go <= 1'b0;
    run(isq_pkg::FLOW_CALL, 10'h380, 10'h380);
    check("still full", full, 1);
    run(isq_pkg::FLOW_SEQ, 0, 10'h381);
    // the waiting interrupt enters in the dummy slot right after the return
    run(isq_pkg::FLOW_RET, 0, 10'h3f0);
    run(isq_pkg::FLOW_SEQ, 0, 10'h3f1);
    run(isq_pkg::FLOW_INTERRUPT_EXIT_INSTR, 0, 10'h301);
    run(isq_pkg::FLOW_RET, 0, 10'h201);
    check("acks", n_ack, 1);
    give_verdict();
  end
  // watchdog, far beyond the hundred or so cycles the sequence needs
  initial
  begin
    #20000;
    n_fail++;
    give_verdict();
  end
endmodule
